// ==== pkg/monitor_pkg.sv ====
/*
  Shared constants and types for the bus event monitor: bus widths, unit counts,
  event source numbering and the counter modes and states.
  Assumes a single system clock domain and a 32-bit CPU address and data bus.
*/
package monitor_pkg;

  // bus and unit sizes
  localparam int ADDR_W  = 32;
  localparam int DATA_W  = 32;
  localparam int MASKN_W = 6;        // low-bit mask count, 0..32
  localparam int NUM_CMP = 4;
  localparam int NUM_SYS = 8;
  localparam int NUM_CNT = 2;
  localparam int CNT_W   = 32;
  localparam int SEL_W   = 4;
  localparam int NUM_SRC = 1 + NUM_CMP + NUM_SYS;

  // positions in the event source vector seen by the counters
  localparam logic [SEL_W-1:0] SRC_CPU  = 4'h0;
  localparam logic [SEL_W-1:0] SRC_CMP0 = 4'h1;
  localparam logic [SEL_W-1:0] SRC_SYS0 = 4'h5;

  // values after reset and limits
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_MAX   = 32'hffff_ffff;
  localparam logic [CNT_W-1:0] CNT_ONE   = 32'h0000_0001;

  typedef enum logic [1:0] {MODE_COUNT, MODE_DURATION, MODE_STAMP} cnt_mode_e;
  typedef enum logic {CNT_IDLE, CNT_RUN} cnt_state_e;

  typedef struct packed {
    cnt_state_e       st;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] stamp;
    logic             evt_d;
    logic             done;
  } cnt_s;

endpackage : monitor_pkg

// ==== pkg/compare_if.sv ====
/*
  Carrier between the monitor top and one bus-compare unit: the watched CPU bus,
  the unit's match settings and the event it returns.
  Assumes all members are driven in the system clock domain.
*/
`timescale 1ns/1ns
interface compare_if;
  import monitor_pkg::*;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  data;
  logic               rd;
  logic               wr;
  logic               fetch;
  logic               en;
  logic               on_read;
  logic               on_write;
  logic               on_fetch;
  logic [ADDR_W-1:0]  ref_addr;
  logic [MASKN_W-1:0] mask_bits;
  logic [DATA_W-1:0]  ref_data;
  logic [DATA_W-1:0]  data_mask;
  logic               evt;
  modport unit (input addr, data, rd, wr, fetch, en, on_read, on_write, on_fetch,
                input ref_addr, mask_bits, ref_data, data_mask, output evt);
  modport host (output addr, data, rd, wr, fetch, en, on_read, on_write, on_fetch,
                output ref_addr, mask_bits, ref_data, data_mask, input evt);
endinterface : compare_if

// ==== rtl/bus_compare_unit.sv ====
/*
  One bus-compare unit: matches the watched CPU access against a reference
  address with low bits masked and a bit-masked data pattern, qualified by kind.
  Assumes bus strobes last one cycle per access.
*/
`timescale 1ns/1ns
module bus_compare_unit
  import monitor_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  compare_if.unit  cmp
);

  typedef struct packed {
    logic evt;
  } unit_s;

  unit_s             st_reg;
  unit_s             st_next;
  logic              kind_ok;
  logic              addr_ok;
  logic              data_ok;
  logic [ADDR_W-1:0] amask;

  // ones in the low n bits; those bits take no part in the address compare
  function automatic logic [ADDR_W-1:0] low_mask(input logic [MASKN_W-1:0] n);
    low_mask = (n >= MASKN_W'(ADDR_W)) ? '1 : ((ADDR_W'(1) << n) - ADDR_W'(1));
  endfunction : low_mask

  // access kind, masked address and masked data must all agree
  always_comb begin
    amask   = low_mask(cmp.mask_bits);
    kind_ok = (cmp.rd & cmp.on_read) | (cmp.wr & cmp.on_write)
            | (cmp.fetch & cmp.on_fetch);
    addr_ok = ((cmp.addr ^ cmp.ref_addr) & ~amask) == '0;
    data_ok = ((cmp.data ^ cmp.ref_data) & ~cmp.data_mask) == '0;
    st_next.evt = cmp.en & kind_ok & addr_ok & data_ok;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmp.evt = st_reg.evt;   // one pulse per matching access

  a_match_fires: assert property (@(posedge clk_sys) disable iff (rst)
    (cmp.en && ((cmp.rd && cmp.on_read) || (cmp.wr && cmp.on_write)
                || (cmp.fetch && cmp.on_fetch))
     && (cmp.mask_bits >= MASKN_W'(ADDR_W)
         || (cmp.addr >> cmp.mask_bits) == (cmp.ref_addr >> cmp.mask_bits))
     && ((cmp.data ^ cmp.ref_data) & ~cmp.data_mask) == '0) |=> cmp.evt)
    else $error("matching access gave no event");

  a_kind_qualified: assert property (@(posedge clk_sys) disable iff (rst)
    cmp.evt |-> $past((cmp.rd && cmp.on_read) || (cmp.wr && cmp.on_write)
                      || (cmp.fetch && cmp.on_fetch)))
    else $error("event without a qualifying access");

  a_range_match: assert property (@(posedge clk_sys) disable iff (rst)
    (cmp.evt && $past(cmp.mask_bits) < MASKN_W'(ADDR_W)) |->
      (($past(cmp.addr) >> $past(cmp.mask_bits))
       == ($past(cmp.ref_addr) >> $past(cmp.mask_bits))))
    else $error("event outside the masked address range");

  a_data_masked: assert property (@(posedge clk_sys) disable iff (rst)
    cmp.evt |-> ((($past(cmp.data) ^ $past(cmp.ref_data)) & ~$past(cmp.data_mask)) == '0)
               && $past(cmp.en))
    else $error("event with unmasked data mismatch");

  c_range_hit: cover property (@(posedge clk_sys) disable iff (rst)
    cmp.evt && $past(cmp.mask_bits) == MASKN_W'(4));

endmodule : bus_compare_unit

// ==== rtl/bus_event_monitor.sv ====
/*
  Run-time bus event monitor: bus-compare units on the CPU bus, sticky flags
  with an interrupt, event export to the logic fabric, and system event counters.
  Assumes configuration arrives on plain ports held steady by surrounding logic,
  and that all inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ns
module bus_event_monitor
  import monitor_pkg::*;
(
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  input  wire logic [ADDR_W-1:0]                 bus_addr,
  input  wire logic [DATA_W-1:0]                 bus_data,
  input  wire logic                              bus_rd,
  input  wire logic                              bus_wr,
  input  wire logic                              bus_fetch,
  input  wire logic                              cpu_active,
  input  wire logic [NUM_SYS-1:0]                sys_evt,
  input  wire logic [NUM_CMP-1:0]                cmp_en,
  input  wire logic [NUM_CMP-1:0]                cmp_on_read,
  input  wire logic [NUM_CMP-1:0]                cmp_on_write,
  input  wire logic [NUM_CMP-1:0]                cmp_on_fetch,
  input  wire logic [NUM_CMP-1:0][ADDR_W-1:0]    cmp_ref_addr,
  input  wire logic [NUM_CMP-1:0][MASKN_W-1:0]   cmp_mask_bits,
  input  wire logic [NUM_CMP-1:0][DATA_W-1:0]    cmp_ref_data,
  input  wire logic [NUM_CMP-1:0][DATA_W-1:0]    cmp_data_mask,
  input  wire logic [NUM_CMP-1:0]                irq_en,
  input  wire logic [NUM_CMP-1:0]                flag_clr,
  input  wire logic [NUM_CNT-1:0]                cnt_en,
  input  wire cnt_mode_e [NUM_CNT-1:0]           cnt_mode,
  input  wire logic [NUM_CNT-1:0][SEL_W-1:0]     cnt_start_sel,
  input  wire logic [NUM_CNT-1:0][SEL_W-1:0]     cnt_stop_sel,
  input  wire logic [NUM_CNT-1:0][SEL_W-1:0]     cnt_evt_sel,
  output wire logic [NUM_CMP-1:0]                fabric_evt,
  output wire logic [NUM_CMP-1:0]                cmp_flag,
  output wire logic                              irq,
  output wire logic [NUM_CNT-1:0]                cnt_running,
  output wire logic [NUM_CNT-1:0]                cnt_done,
  output wire logic [NUM_CNT-1:0][CNT_W-1:0]     cnt_value,
  output wire logic [NUM_CNT-1:0][CNT_W-1:0]     cnt_stamp
);

  typedef struct packed {
    cnt_s [NUM_CNT-1:0] cnt;
    logic [CNT_W-1:0]   timebase;
    logic [NUM_CMP-1:0] flag;
  } mon_s;

  mon_s               st_reg;
  mon_s               st_next;
  logic [NUM_CMP-1:0] cmp_evt;
  logic [NUM_SRC-1:0] src;

  // pick one source out of the event vector; out-of-range selects read as idle
  function automatic logic pick(input logic [NUM_SRC-1:0] v, input logic [SEL_W-1:0] sel);
    pick = (sel < SEL_W'(NUM_SRC)) ? v[sel] : 1'b0;
  endfunction : pick

  // one compare unit per slot, each on its own carrier
  generate
    for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
      compare_if cif ();
      assign cif.addr      = bus_addr;
      assign cif.data      = bus_data;
      assign cif.rd        = bus_rd;
      assign cif.wr        = bus_wr;
      assign cif.fetch     = bus_fetch;
      assign cif.en        = cmp_en[i];
      assign cif.on_read   = cmp_on_read[i];
      assign cif.on_write  = cmp_on_write[i];
      assign cif.on_fetch  = cmp_on_fetch[i];
      assign cif.ref_addr  = cmp_ref_addr[i];
      assign cif.mask_bits = cmp_mask_bits[i];
      assign cif.ref_data  = cmp_ref_data[i];
      assign cif.data_mask = cmp_data_mask[i];
      assign cmp_evt[i]    = cif.evt;
      bus_compare_unit u_cmp (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cmp     (cif.unit)
      );
    end
  endgenerate

  // source vector: cpu activity, compare events, then system events
  always_comb begin
    src = '0;
    src[SRC_CPU] = cpu_active;
    src[SRC_CMP0 +: NUM_CMP] = cmp_evt;
    src[SRC_SYS0 +: NUM_SYS] = sys_evt;
  end

  // next state: free timebase, sticky flags, and one small machine per counter
  always_comb begin
    logic s_hit;
    logic p_hit;
    logic e_hit;
    s_hit = 1'b0;
    p_hit = 1'b0;
    e_hit = 1'b0;
    st_next = st_reg;
    st_next.timebase = st_reg.timebase + CNT_ONE;
    // a new event beats a clear in the same cycle so no hit is lost
    st_next.flag = (st_reg.flag & ~flag_clr) | cmp_evt;
    for (int c = 0; c < NUM_CNT; c++) begin
      s_hit = pick(src, cnt_start_sel[c]);
      p_hit = pick(src, cnt_stop_sel[c]);
      e_hit = pick(src, cnt_evt_sel[c]);
      st_next.cnt[c].done  = 1'b0;
      st_next.cnt[c].evt_d = e_hit;
      unique case (st_reg.cnt[c].st)
        CNT_IDLE: begin
          if (cnt_en[c] && s_hit) begin
            st_next.cnt[c].st    = CNT_RUN;
            st_next.cnt[c].count = CNT_RESET;
          end
        end
        CNT_RUN: begin
          if (!cnt_en[c]) begin
            st_next.cnt[c].st = CNT_IDLE;
          end else if (p_hit) begin
            // stop wins over a same-cycle event; the result stays in count
            st_next.cnt[c].st   = CNT_IDLE;
            st_next.cnt[c].done = 1'b1;
          end else begin
            // counts saturate rather than wrap so a long run never reads small
            case (cnt_mode[c])
              MODE_COUNT: begin
                if (e_hit && !st_reg.cnt[c].evt_d && st_reg.cnt[c].count != CNT_MAX) begin
                  st_next.cnt[c].count = st_reg.cnt[c].count + CNT_ONE;
                end
              end
              MODE_DURATION: begin
                if (e_hit && st_reg.cnt[c].count != CNT_MAX) begin
                  st_next.cnt[c].count = st_reg.cnt[c].count + CNT_ONE;
                end
              end
              MODE_STAMP: begin
                if (e_hit) begin
                  st_next.cnt[c].stamp = st_reg.timebase;
                end
              end
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs from the registers; fabric_evt is the units' evt, irq gates the flags with irq_en
  assign fabric_evt = cmp_evt;
  assign cmp_flag   = st_reg.flag;
  assign irq        = |(st_reg.flag & irq_en);
  generate
    for (genvar c = 0; c < NUM_CNT; c++) begin : g_out
      assign cnt_running[c] = (st_reg.cnt[c].st == CNT_RUN);
      assign cnt_done[c]    = st_reg.cnt[c].done;
      assign cnt_value[c]   = st_reg.cnt[c].count;
      assign cnt_stamp[c]   = st_reg.cnt[c].stamp;
    end
  endgenerate

  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_evt[0] |=> cmp_flag[0] [*2] or (cmp_flag[0] ##1 $past(flag_clr[0])))
    else $error("flag not set or not held after event");

  a_irq_gated: assert property (@(posedge clk_sys) disable iff (rst)
    (cmp_evt[0] && irq_en[0]) |=> irq)
    else $error("enabled event gave no interrupt");

  a_fabric_export: assert property (@(posedge clk_sys) disable iff (rst)
    fabric_evt[0] |-> $past(cmp_en[0] && (bus_rd || bus_wr || bus_fetch)) ##1 cmp_flag[0])
    else $error("exported event without a bus access");

  a_sys_count: assert property (@(posedge clk_sys) disable iff (rst)
    (cnt_running[1] && cnt_en[1] && cnt_mode[1] == MODE_DURATION
     && pick(src, cnt_evt_sel[1]) && !pick(src, cnt_stop_sel[1])
     && cnt_value[1] != CNT_MAX)
    |=> cnt_value[1] == $past(cnt_value[1]) + CNT_ONE)
    else $error("duration count missed an event cycle");

  a_stamp_take: assert property (@(posedge clk_sys) disable iff (rst)
    (cnt_running[1] && cnt_en[1] && cnt_mode[1] == MODE_STAMP
     && pick(src, cnt_evt_sel[1]) && !pick(src, cnt_stop_sel[1]))
    |=> cnt_stamp[1] == $past(st_reg.timebase))
    else $error("time stamp not taken");

  a_start_clears: assert property (@(posedge clk_sys) disable iff (rst)
    (!cnt_running[0] && cnt_en[0] && pick(src, cnt_start_sel[0]))
    |=> cnt_running[0] && cnt_value[0] == CNT_RESET)
    else $error("start event did not begin a clean run");

  a_stop_done: assert property (@(posedge clk_sys) disable iff (rst)
    (cnt_running[0] && cnt_en[0] && pick(src, cnt_stop_sel[0]))
    |=> !cnt_running[0] && cnt_done[0] ##1 !cnt_done[0])
    else $error("stop event did not end the run with one done pulse");

  c_irq_raised: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
  c_run_done: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(cnt_running[0]) ##[1:50] cnt_done[0]);
  c_flag_race: cover property (@(posedge clk_sys) disable iff (rst)
    cmp_evt[0] && flag_clr[0]);

endmodule : bus_event_monitor

// ==== test/cpu_bus_model.sv ====
/*
  Model of the CPU side of the watched bus: issues single-cycle read, write
  and fetch accesses on request of the bench.
  Assumes the bench calls access from its main thread, one access at a time.
*/
`timescale 1ns/1ns
module cpu_bus_model
  import monitor_pkg::*;
(
  input  wire logic              clk_sys,
  output logic [ADDR_W-1:0]      bus_addr,
  output logic [DATA_W-1:0]      bus_data,
  output logic                   bus_rd,
  output logic                   bus_wr,
  output logic                   bus_fetch
);
  initial begin
    bus_addr  = 32'h0000_0000;
    bus_data  = 32'h0000_0000;
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_fetch = 1'b0;
  end

  // kind bits: 0 read, 1 write, 2 fetch; the strobe lasts exactly one cycle
  task automatic access(input logic [2:0] kind, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus_addr  <= a;
    bus_data  <= d;
    bus_rd    <= kind[0];
    bus_wr    <= kind[1];
    bus_fetch <= kind[2];
    @(posedge clk_sys);
    bus_rd    <= 1'b0;
    bus_wr    <= 1'b0;
    bus_fetch <= 1'b0;
    // idle bus shows inverted leftovers so stale values never match by luck
    bus_addr  <= ~a;
    bus_data  <= ~d;
  endtask : access
endmodule : cpu_bus_model

// ==== test/bus_event_monitor_test.sv ====
/*
  Self-checking bench for the bus event monitor: compare units, flags, irq and
  the event counters in count, duration and time-stamp modes.
  Assumes the cpu_bus_model partner and the monitor package.
*/
`timescale 1ns/1ns
module bus_event_monitor_test
  import monitor_pkg::*;
;
  logic                          clk_sys;
  logic                          rst;
  logic [ADDR_W-1:0]             bus_addr;
  logic [DATA_W-1:0]             bus_data;
  logic                          bus_rd, bus_wr, bus_fetch, cpu_active;
  logic [NUM_SYS-1:0]            sys_evt;
  logic [NUM_CMP-1:0]            cmp_en, cmp_on_read, cmp_on_write, cmp_on_fetch;
  logic [NUM_CMP-1:0][ADDR_W-1:0]  cmp_ref_addr;
  logic [NUM_CMP-1:0][MASKN_W-1:0] cmp_mask_bits;
  logic [NUM_CMP-1:0][DATA_W-1:0]  cmp_ref_data, cmp_data_mask;
  logic [NUM_CMP-1:0]            irq_en, flag_clr, fabric_evt, cmp_flag;
  logic [NUM_CNT-1:0]            cnt_en, cnt_running, cnt_done;
  cnt_mode_e [NUM_CNT-1:0]       cnt_mode;
  logic [NUM_CNT-1:0][SEL_W-1:0] cnt_start_sel, cnt_stop_sel, cnt_evt_sel;
  logic [NUM_CNT-1:0][CNT_W-1:0] cnt_value, cnt_stamp;
  logic                          irq;
  int                            n_errors;
  int                            check_count;
  logic [CNT_W-1:0]              s1;

  cpu_bus_model u_cpu_bus_model (.clk_sys(clk_sys), .bus_addr(bus_addr),
    .bus_data(bus_data), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_fetch(bus_fetch));

  bus_event_monitor u_bus_event_monitor (.clk_sys(clk_sys), .rst(rst),
    .bus_addr(bus_addr), .bus_data(bus_data), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_fetch(bus_fetch), .cpu_active(cpu_active), .sys_evt(sys_evt),
    .cmp_en(cmp_en), .cmp_on_read(cmp_on_read), .cmp_on_write(cmp_on_write),
    .cmp_on_fetch(cmp_on_fetch), .cmp_ref_addr(cmp_ref_addr),
    .cmp_mask_bits(cmp_mask_bits), .cmp_ref_data(cmp_ref_data),
    .cmp_data_mask(cmp_data_mask), .irq_en(irq_en), .flag_clr(flag_clr),
    .cnt_en(cnt_en), .cnt_mode(cnt_mode), .cnt_start_sel(cnt_start_sel),
    .cnt_stop_sel(cnt_stop_sel), .cnt_evt_sel(cnt_evt_sel),
    .fabric_evt(fabric_evt), .cmp_flag(cmp_flag), .irq(irq),
    .cnt_running(cnt_running), .cnt_done(cnt_done), .cnt_value(cnt_value),
    .cnt_stamp(cnt_stamp));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // one-cycle pulse on a system event line
  task automatic pulse_sys(input int i);
    @(posedge clk_sys);
    sys_evt[i] <= 1'b1;
    @(posedge clk_sys);
    sys_evt[i] <= 1'b0;
  endtask : pulse_sys

  // unit0 guards a 16-byte stack window on writes; boundaries and wrong kind
  task automatic s_stack();
    logic [2:0]  kind [5] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h1};
    logic [31:0] adr  [5] = '{32'h0009_9ff5, 32'h0009_9fff, 32'h0009_a000,
                              32'h0009_9fef, 32'h0009_9ff5};
    logic [3:0]  exp  [5] = '{4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
    for (int k = 0; k < 5; k++) begin
      u_cpu_bus_model.access(kind[k], adr[k], 32'h5555_0000);
      #1 check(fabric_evt, exp[k], "stack event");
      @(posedge clk_sys);
      #1 check(fabric_evt, 4'h0, "event pulse width");
    end
    check(cmp_flag, 4'h1, "stack flag");
    check(irq, 1'b1, "stack irq");
    flag_clr[0] <= 1'b1;
    @(posedge clk_sys);
    flag_clr[0] <= 1'b0;
    #1 check(cmp_flag, 4'h0, "flag cleared");
    check(irq, 1'b0, "irq cleared");
  endtask : s_stack

  // unit1 matches a read data word, unit2 an instruction fetch without irq
  task automatic s_data();
    u_cpu_bus_model.access(3'h1, 32'h0000_0100, 32'h0000_1235);
    #1 check(fabric_evt, 4'h0, "data off by one");
    u_cpu_bus_model.access(3'h1, 32'h0000_0101, 32'h0000_1234);
    #1 check(fabric_evt, 4'h0, "address off by one");
    u_cpu_bus_model.access(3'h1, 32'h0000_0100, 32'h0000_1234);
    #1 check(fabric_evt, 4'h2, "data match");
    // clear lands on the same edge that sets flag1; the set must win
    flag_clr <= 4'h2;
    @(posedge clk_sys);
    flag_clr <= 4'h0;
    #1 check(cmp_flag[1], 1'b1, "set beats clear");
    u_cpu_bus_model.access(3'h4, 32'h0000_0777, 32'habcd_0001);
    #1 check(fabric_evt, 4'h4, "fetch match");
    @(posedge clk_sys);
    #1 check(cmp_flag, 4'h6, "flags set");
    check(irq, 1'b1, "irq from unit1");
    flag_clr <= 4'h2;
    @(posedge clk_sys);
    flag_clr <= 4'h4;
    #1 check(cmp_flag, 4'h4, "unit2 flag kept");
    check(irq, 1'b0, "masked flag gives no irq");
    @(posedge clk_sys);
    flag_clr <= 4'h0;
    #1 check(cmp_flag, 4'h0, "flags cleared");
  endtask : s_data

  // counter0 counts rising edges of sys_evt[1] between start and stop
  task automatic s_count();
    pulse_sys(0);
    #1 check(cnt_running[0], 1'b1, "count running");
    check(cnt_value[0], 32'h0, "count cleared");
    pulse_sys(1);
    @(posedge clk_sys);
    sys_evt[1] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_evt[1] <= 1'b0;
    @(posedge clk_sys);
    pulse_sys(2);
    #1 check({cnt_running[0], cnt_done[0]}, 2'b01, "count stop");
    check(cnt_value[0], 32'h2, "count value");
    @(posedge clk_sys);
    #1 check(cnt_done[0], 1'b0, "done one cycle");
    check(cnt_value[0], 32'h2, "count held");
    check(cnt_stamp[0], CNT_RESET, "count mode takes no stamp");
  endtask : s_count

  // counter1 measures cpu_active cycles, then time-stamps sys_evt[5]
  task automatic s_duration_stamp();
    pulse_sys(3);
    @(posedge clk_sys);
    cpu_active <= 1'b1;
    repeat (5) @(posedge clk_sys);
    cpu_active <= 1'b0;
    pulse_sys(4);
    #1 check(cnt_value[1], 32'h5, "duration");
    check({cnt_running[1], cnt_done[1]}, 2'b01, "duration stop");
    cnt_mode[1] <= MODE_STAMP;
    cnt_evt_sel[1] <= 4'ha;
    pulse_sys(3);
    pulse_sys(5);
    #1 s1 = cnt_stamp[1];
    repeat (7) @(posedge clk_sys);
    pulse_sys(5);
    #1 check(cnt_stamp[1] - s1, 32'h9, "stamp spacing");
    check(cnt_value[1], 32'h0, "stamp keeps value");
  endtask : s_duration_stamp

  // watchdog: the whole run takes well under 200 cycles
  initial begin
    #20000;
    n_errors++;
    summarize();
  end

  initial begin
    n_errors = 0;
    check_count = 0;
    rst = 1'b1;
    cpu_active = 1'b0;
    sys_evt = '0;
    cmp_en = 4'h7;
    cmp_on_read = 4'h2;
    cmp_on_write = 4'h9;
    cmp_on_fetch = 4'h4;
    cmp_ref_addr = {32'h0, 32'h0, 32'h0000_0100, 32'h0009_9ff0};
    cmp_mask_bits = {6'h20, 6'h20, 6'h00, 6'h04};
    cmp_ref_data = {32'h0, 32'habcd_0001, 32'h0000_1234, 32'h0};
    cmp_data_mask = {32'hffff_ffff, 32'h0, 32'h0, 32'hffff_ffff};
    irq_en = 4'h3;
    flag_clr = 4'h0;
    cnt_en = 2'h3;
    cnt_mode[1] = MODE_DURATION;
    cnt_mode[0] = MODE_COUNT;
    cnt_start_sel = {4'h8, 4'h5};
    cnt_stop_sel = {4'h9, 4'h7};
    cnt_evt_sel = {4'ha, 4'h6};
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    cnt_evt_sel[1] <= SRC_CPU;
    s_stack();
    s_data();
    s_count();
    s_duration_stamp();
    summarize();
  end
endmodule : bus_event_monitor_test
